// ### mcs_clock_ctl.v
// Purpose: CPU clock source select, peripheral clock enable, stabilization counter
// Assumes: pclk samples all inputs; crystal and ring clocks arrive as one-cycle ticks
// Notes:   register map on APB, zero wait states
// Functional notes
// - With the ring oscillator as CPU source, peripherals get the undivided ring clock tick.
// - Watchdog, clock monitor and interval timer at ring over 128 keep a clock on ring.
// - Externally clocked peripherals stay enabled on ring, except capture timer external edge.
// - Stabilization status bits set one after another from the first and stay set until stop mode clears them.
// - The counter stops at the selected stabilization time, so status stops there too.
// - The wait excludes the time from stop release until the oscillator starts.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "mcs_consts.vh"
module mcs_clock_ctl (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        crystal_tick,
   input  wire        ring_tick,
   input  wire        osc_started,
   input  wire        stop_release,
   input  wire        capt_ext_sel,
   output reg         cpu_clock_source_flag,
   output reg         periph_clk_en,
   output reg         safe_periph_clk_en,
   output reg         ext_periph_clk_en,
   output reg         capture_timer_a_clk_en,
   output reg         main_osc_stop_bit,
   output reg         stop_mode
);
   // Control and status state
   reg                        mode_sel;      // 1 selects ring clock
   reg  [`MCS_TSEL_W-1:0]     stab_time_select_reg;
   reg  [`MCS_CNT_W-1:0]      stab_cnt;
   reg  [`MCS_STAB_W-1:0]     stab_counter_status_reg;
   reg                        osc_running;
   reg  [`MCS_RING_DIV_W-1:0] ring_div;
   reg  [31:0]                next_rdata;

   // Bus strobes and address decode
   wire                       wr;
   wire                       rd;
   wire                       setup;
   wire                       hit_mode;
   wire                       hit_osc;
   wire                       hit_tsel;
   wire                       hit_stop;
   wire                       unmapped;
   wire                       misaligned;
   wire                       tsel_ok;
   wire [`MCS_TSEL_W-1:0]     wr_tsel;

   // Stabilization count control
   wire [`MCS_CNT_W-1:0]      cnt_one;
   wire [`MCS_CNT_W-1:0]      stab_limit;
   wire                       cnt_at_limit;
   wire                       cnt_step;
   wire [`MCS_STAB_W-1:0]     sel_hit_v;

   // Ring divider wrap marks every 128th ring tick
   wire                       div_wrap;

   // Write and read strobes; read data is latched in the setup cycle
   assign setup = psel & ~penable;
   assign wr    = psel & penable & pwrite;
   assign rd    = setup & ~pwrite;

   // Register decode on the byte address
   assign hit_mode   = (paddr == `MCS_MODE_OFF);
   assign hit_osc    = (paddr == `MCS_OSC_OFF);
   assign hit_tsel   = (paddr == `MCS_TSEL_OFF);
   assign hit_stop   = (paddr == `MCS_STOP_OFF);
   assign unmapped   = (paddr > `MCS_STOP_OFF);
   assign misaligned = (paddr[1:0] != 2'h0);

   // Select codes past the last status bit are refused
   assign wr_tsel = pwdata[`MCS_TSEL_W-1:0];
   assign tsel_ok = (wr_tsel < `MCS_STAB_W);

   // Count target is 2^(11+select) crystal ticks; the count holds there
   assign cnt_one      = {{(`MCS_CNT_W-1){1'b0}}, 1'b1};
   assign stab_limit   = cnt_one << (`MCS_STAB_BASE + stab_time_select_reg);
   assign cnt_at_limit = (stab_cnt >= stab_limit);
   assign cnt_step     = osc_running & crystal_tick & ~cnt_at_limit;

   // Ring divider all ones: this tick completes a divide by 128
   assign div_wrap = ring_tick & (&ring_div);

   // Status bit n rises at threshold 2^(11+n), first bit first
   genvar g;
   generate
      for (g = 0; g < `MCS_STAB_W; g = g + 1) begin : g_stat
         assign sel_hit_v[g] = (stab_cnt >= (cnt_one << (`MCS_STAB_BASE + g)));
      end
   endgenerate

   // Mode select bit, read back beside the source flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sel <= 1'b0;
      end else if (wr && hit_mode) begin
         mode_sel <= pwdata[`MCS_SEL_BIT];
      end
   end

   // Main oscillator stop bit; software checks the source flag first
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_osc_stop_bit <= 1'b0;
      end else if (wr && hit_osc) begin
         main_osc_stop_bit <= pwdata[`MCS_MAIN_OSC_STOP_BIT_BIT];
      end
   end

   // Stabilization time select; out-of-range codes leave it unchanged
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stab_time_select_reg <= `MCS_TSEL_RST;
      end else if (wr && hit_tsel && tsel_ok) begin
         stab_time_select_reg <= wr_tsel;
      end
   end

   // Stop mode: a write enters it, a release leaves it; the write wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_mode <= 1'b0;
      end else if (wr && hit_stop) begin
         stop_mode <= 1'b1;
      end else if (stop_release) begin
         stop_mode <= 1'b0;
      end
   end

   // Stabilization counter: cleared in stop, waits for oscillation start
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stab_cnt                <= {`MCS_CNT_W{1'b0}};
         stab_counter_status_reg <= {`MCS_STAB_W{1'b0}};
         osc_running             <= 1'b0;
      end else if (stop_mode) begin
         stab_cnt                <= {`MCS_CNT_W{1'b0}};
         stab_counter_status_reg <= {`MCS_STAB_W{1'b0}};
         osc_running             <= 1'b0;
      end else begin
         if (osc_started)
            osc_running <= 1'b1;
         if (cnt_step)
            stab_cnt <= stab_cnt + cnt_one;
         stab_counter_status_reg <= stab_counter_status_reg | sel_hit_v;
      end
   end

   // Source flag and peripheral clock enables
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_clock_source_flag  <= 1'b0;
         ring_div               <= {`MCS_RING_DIV_W{1'b0}};
         periph_clk_en          <= 1'b0;
         safe_periph_clk_en     <= 1'b0;
         ext_periph_clk_en      <= 1'b0;
         capture_timer_a_clk_en <= 1'b0;
      end else begin
         cpu_clock_source_flag <= mode_sel;
         if (ring_tick)
            ring_div <= ring_div + {{(`MCS_RING_DIV_W-1){1'b0}}, 1'b1};
         if (cpu_clock_source_flag) begin
            periph_clk_en      <= ring_tick;
            safe_periph_clk_en <= div_wrap;
            ext_periph_clk_en  <= 1'b1;
            capture_timer_a_clk_en <= ~capt_ext_sel;
         end else begin
            periph_clk_en          <= crystal_tick;
            safe_periph_clk_en     <= crystal_tick;
            ext_periph_clk_en      <= 1'b1;
            capture_timer_a_clk_en <= 1'b1;
         end
      end
   end

   // Read mux for APB
   always @* begin
      next_rdata = 32'h00000000;
      case (paddr)
         `MCS_MODE_OFF: next_rdata = {30'h0, cpu_clock_source_flag, mode_sel};
         `MCS_OSC_OFF:  next_rdata = {31'h0, main_osc_stop_bit};
         `MCS_STAB_OFF: next_rdata = {27'h0, stab_counter_status_reg};
         `MCS_TSEL_OFF: next_rdata = {29'h0, stab_time_select_reg};
         `MCS_STOP_OFF: next_rdata = {31'h0, stop_mode};
         default:       next_rdata = 32'h00000000;
      endcase
   end

   // APB answer: data captured in setup, ready in access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (rd)
            prdata <= next_rdata;
         pready  <= setup;
         pslverr <= setup & (unmapped | misaligned);
      end
   end
endmodule // mcs_clock_ctl

// ### mcs_consts.vh
// Purpose: constants for the main clock select and stabilization block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   field positions and reset values of the control registers
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH
`define MCS_MODE_OFF     12'h000
`define MCS_OSC_OFF      12'h004
`define MCS_STAB_OFF     12'h008
`define MCS_TSEL_OFF     12'h00C
`define MCS_STOP_OFF     12'h010
`define MCS_SEL_BIT      0
`define MCS_SRC_BIT      1
`define MCS_MAIN_OSC_STOP_BIT_BIT    0
`define MCS_TSEL_W       3
`define MCS_TSEL_RST     3'h5
`define MCS_STAB_W       5
`define MCS_CNT_W        18
`define MCS_STAB_BASE    11
`define MCS_RING_DIV_W   7
`define MCS_RING_KHZ     240
`endif

// ### mcs_ctl_chk_assertions.sv
// Purpose: port checks for the clock select block
// Assumes: zero wait state APB, ticks sampled on pclk
// Notes: bound to every instance below
`timescale 1ns/1ps
module mcs_ctl_chk (
   input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr, ring_tick,
   input wire        capt_ext_sel, cpu_clock_source_flag, periph_clk_en, safe_periph_clk_en,
   input wire        ext_periph_clk_en, capture_timer_a_clk_en, stop_release, stop_mode,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase of a transfer
   wire acc = psel & penable;
   a_ready_zero: assert property (psel && !penable |=> pready) else $error("late ready");
   a_ready_access: assert property (pready |-> acc) else $error("stray ready");
   a_flag_follow: assert property (acc && pwrite && paddr == 12'h000 |-> ##2
      cpu_clock_source_flag == $past(pwdata[0], 2)) else $error("source flag lag");
   a_ring_pass: assert property (cpu_clock_source_flag && $past(cpu_clock_source_flag)
      && ring_tick |=> periph_clk_en) else $error("ring tick lost");
   a_safe_ring: assert property ($past(cpu_clock_source_flag) && safe_periph_clk_en
      |-> $past(ring_tick)) else $error("safe tick off ring");
   a_capt_gate: assert property ((capt_ext_sel && cpu_clock_source_flag) [*2]
      |-> !capture_timer_a_clk_en) else $error("capture clock on ring");
   a_ext_keep: assert property (ext_periph_clk_en |=> ext_periph_clk_en)
      else $error("ext clock dropped");
   a_stop_enter: assert property (acc && pwrite && paddr == 12'h010 |=> stop_mode)
      else $error("stop not entered");
   a_status_fill: assert property (pready && !pwrite && paddr == 12'h008 |->
      (prdata[4:0] & (prdata[4:0] + 5'h01)) == 5'h00 && prdata[31:5] == 27'h0)
      else $error("status out of order");
   c_release: cover property (stop_release);
   c_safe: cover property (safe_periph_clk_en);
   c_err: cover property (pready && pslverr);
endmodule // mcs_ctl_chk
bind mcs_clock_ctl mcs_ctl_chk u_chk (.*);

// ### mcs_osc_model.sv
// Purpose: oscillator side model feeding ticks
// Assumes: ring runs free, crystal halts while stopped
// Notes: crystal ticks before start is flagged, to be ignored
`timescale 1ns/1ps
module mcs_osc_model #(parameter START_DLY = 3000) (
   input wire pclk, presetn, main_osc_stop_bit, stop_mode, stop_release,
   output reg crystal_tick, ring_tick, osc_started
);
   reg [1:0] rdiv;
   integer   wait_n;
   // Ring divider and start delay after release
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdiv <= 2'h0;
         wait_n <= 0;
      end else begin
         rdiv <= rdiv + 2'h1;
         if (stop_release) wait_n <= START_DLY;
         else if (wait_n > 0) wait_n <= wait_n - 1;
      end
   end
   // Tick outputs
   always @* begin
      ring_tick = (rdiv == 2'h3);
      osc_started = (wait_n == 1);
      crystal_tick = !main_osc_stop_bit && !stop_mode;
   end
endmodule // mcs_osc_model

// ### main_clock_select_and_osc_stabilization_tb.sv
// Purpose: register level test of the clock select block
// Assumes: zero wait APB, start delay 3000 cycles
// Notes: status counts 2^(11+n) crystal ticks
`timescale 1ns/1ps
module main_clock_select_and_osc_stabilization_tb;
   reg        pclk, presetn, psel, penable, pwrite, stop_release, capt_ext_sel, e;
   reg [11:0] paddr;
   reg [31:0] pwdata, q;
   wire [31:0] prdata;
   wire        pready, pslverr, crystal_tick, ring_tick, osc_started, cpu_clock_source_flag;
   wire        periph_clk_en, safe_periph_clk_en, ext_periph_clk_en, capture_timer_a_clk_en;
   wire        main_osc_stop_bit, stop_mode;
   integer     fails, checks;
   mcs_clock_ctl DUT (.*);
   mcs_osc_model u_osc (.*);
   // One APB transfer, held until ready
   task apb(input [11:0] a, input w, input [31:0] d);
      integer n;
      begin
         @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
         @(posedge pclk) penable <= 1'b1;
         n = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20) begin n = n + 1; @(posedge pclk); end
         if (pready !== 1'b1) begin fails = fails + 1; $display("ERROR pready exp 1 got %b", pready); end
         q = prdata;
         e = pslverr;
         {psel, penable} <= 2'b00;
      end
   endtask
   task chk(input string nm, input [31:0] x, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== x) begin fails = fails + 1; $display("ERROR %s exp %h got %h", nm, x, g); end
      end
   endtask
   task rel(input integer n);
      begin
         @(posedge pclk) stop_release <= 1'b1;
         @(posedge pclk) stop_release <= 1'b0;
         repeat (n) @(posedge pclk);
      end
   endtask
   task results;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin pclk = 0; forever #2 pclk = ~pclk; end
   initial begin #150000 fails = fails + 1; results; end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, stop_release, capt_ext_sel} = 6'h0;
      paddr = 12'h000; pwdata = 32'h0; fails = 0; checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(12'h00C, 0, 0); chk("select reset", 32'h5, q);
      apb(12'h020, 0, 0); chk("unmapped data", 32'h0, q); chk("unmapped err", 1, e);
      apb(12'h000, 0, 0); chk("source flag", 32'h0, q);
      apb(12'h004, 1, 1); apb(12'h004, 0, 0); chk("osc stop", 32'h1, q);
      apb(12'h004, 1, 0);
      apb(12'h00C, 1, 0); apb(12'h010, 1, 0);
      apb(12'h010, 0, 0); chk("stop mode", 32'h1, q);
      rel(2500); apb(12'h008, 0, 0); chk("status pre start", 32'h0, q);
      repeat (3000) @(posedge pclk);
      apb(12'h008, 0, 0); chk("status sel0", 32'h01, q);
      apb(12'h00C, 1, 2); apb(12'h010, 1, 0);
      apb(12'h008, 0, 0); chk("status cleared", 32'h0, q);
      rel(11700); apb(12'h008, 0, 0); chk("status sel2", 32'h07, q);
      apb(12'h000, 1, 1); capt_ext_sel <= 1'b1;
      repeat (600) @(posedge pclk);
      apb(12'h000, 0, 0); chk("ring mode", 32'h3, q);
      results;
   end
endmodule // main_clock_select_and_osc_stabilization_tb
